// File: core/txpa_pkg.sv
package txpa_pkg;

    // =====================================================================
    // three-level select encoding
    typedef enum logic [1:0] {
        TXPA_LVL_LOW  = 2'b00,
        TXPA_LVL_MID  = 2'b01,
        TXPA_LVL_HIGH = 2'b10
    } txpa_lvl_type;

    // =====================================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int REF_PERIOD_NS = 80;
    localparam int REF_DIV       = (REF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] REF_DIV_LAST = 4'(REF_DIV - 1);
    localparam logic [3:0] REF_DIV_HALF = 4'(REF_DIV / 2);
    localparam logic [1:0] RST_LOW_EDGES = 2'h2;

    // =====================================================================
    // character layout and fixed patterns
    localparam int DATA_W   = 8;
    localparam int CTRL_W   = 2;
    localparam int WORD_W   = DATA_W + CTRL_W + 1;
    localparam int SC_BIT   = DATA_W + CTRL_W;
    localparam logic [9:0] VIOLATION_CHAR = 10'b1001111000;
    localparam logic [7:0] COMMA_CODE     = 8'hbc;
    localparam logic [4:0] WSYNC_LEN      = 5'h10;

    // =====================================================================
    // phase-align buffer
    localparam int BUF_DEPTH = 4;
    localparam int BUF_AW    = 2;
    localparam logic [BUF_AW:0] BUF_CENTER = 3'h2;

    // =====================================================================
    // register map
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_INT_STAT = 8'h08;
    localparam logic [7:0] REG_INT_MASK = 8'h0c;
    localparam int CTRL_RECENTER = 0;
    localparam int INT_ERR       = 0;
    localparam int INT_INIT_DONE = 1;
    localparam int INT_SYNC_DONE = 2;
    localparam logic [2:0] INT_MASK_RESET = 3'h0;

endpackage

// File: core/txpa_buf_if.sv
`timescale 1ns/1ps
`default_nettype none
interface txpa_buf_if;
    import txpa_pkg::*;
    logic                  init;
    logic                  wr_en;
    logic [WORD_W-1:0]     wr_data;
    logic                  rd_en;
    logic [WORD_W-1:0]     rd_data;
    logic                  overflow;
    logic                  underflow;
    logic [BUF_AW:0]       level;

    modport ctl (output init, wr_en, wr_data, rd_en,
                 input rd_data, overflow, underflow, level);
    modport buf_side (input init, wr_en, wr_data, rd_en,
                      output rd_data, overflow, underflow, level);
endinterface
`default_nettype wire

// File: core/txpa_phase_buf.sv
`timescale 1ns/1ps
`default_nettype none
module txpa_phase_buf
    import txpa_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // buffer port
    txpa_buf_if.buf_side bus
);

    logic [WORD_W-1:0] mem [BUF_DEPTH];
    logic [BUF_AW:0]   wptr;
    logic [BUF_AW:0]   rptr;
    logic              full;
    logic              empty;

    assign full  = (wptr - rptr) == 3'(BUF_DEPTH);
    assign empty = (wptr == rptr);
    assign bus.level = wptr - rptr;

    // =====================================================================
    // pointers: centered on init so drift has room both ways
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || bus.init)
        begin
            wptr <= BUF_CENTER;
            rptr <= '0;
        end
        else
        begin
            if (bus.wr_en && !full)
                wptr <= wptr + 3'h1;
            if (bus.rd_en && !empty)
                rptr <= rptr + 3'h1;
        end
    end

    // storage; centered slots hold idle zero words
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || bus.init)
        begin
            for (int i = 0; i < BUF_DEPTH; i++)
                mem[i] <= '0;
        end
        else if (bus.wr_en && !full)
            mem[wptr[BUF_AW-1:0]] <= bus.wr_data;
    end

    // read data and error pulses
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || bus.init)
        begin
            bus.rd_data   <= '0;
            bus.overflow  <= 1'b0;
            bus.underflow <= 1'b0;
        end
        else
        begin
            bus.overflow  <= bus.wr_en && full;
            bus.underflow <= bus.rd_en && empty;
            if (bus.rd_en && !empty)
                bus.rd_data <= mem[rptr[BUF_AW-1:0]];
        end
    end

endmodule // txpa_phase_buf
`default_nettype wire

// File: core/txpa_top.sv
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module txpa_top
    import txpa_pkg::*;
(
    // system
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    // apb slave
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [7:0]        paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic      [31:0]       prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    output logic                   irq_o,
    // host character interface (pins)
    input  wire logic              tx_input_clk_i,
    input  wire logic [DATA_W-1:0] tx_data_i,
    input  wire logic [CTRL_W-1:0] tx_ctrl_in_i,
    input  wire logic              special_char_sel_i,
    input  wire logic [1:0]        tx_mode_sel1_i,
    input  wire logic [1:0]        tx_mode_sel0_i,
    input  wire logic              tx_input_clk_sel_i,
    input  wire logic              tx_rate_sel_i,
    input  wire logic              tx_phase_reset_n_i,
    input  wire logic              word_sync_req_i,
    // character out to encoder
    output logic      [9:0]        tx_char_o,
    output logic                   tx_char_valid_o,
    output logic                   tx_special_sel_o,
    output logic                   tx_encode_en_o,
    output logic                   tx_violation_o,
    output logic                   tx_comma_o,
    output logic                   tx_error_flag_o
);

    localparam int PIN_W = 20;

    typedef enum logic [0:0] {
        TXPA_WS_IDLE = 1'b0,
        TXPA_WS_SEND = 1'b1
    } txpa_ws_type;

    function automatic logic is_lvl(input logic [1:0] v, input txpa_lvl_type l);
        is_lvl = (v == l);
    endfunction

    // =====================================================================
    // pin synchronizers
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_meta;
    logic [PIN_W-1:0] pin_s;
    assign pin_raw = {tx_input_clk_i, tx_phase_reset_n_i, word_sync_req_i, tx_rate_sel_i,
                      tx_input_clk_sel_i, tx_mode_sel1_i, tx_mode_sel0_i,
                      special_char_sel_i, tx_ctrl_in_i, tx_data_i};

    genvar g;
    generate
        for (g = 0; g < PIN_W; g++)
        begin : g_sync
            // two stages; only the second one feeds logic
            always_ff @(posedge clk_i)
            begin
                if (!rst_n_i)
                begin
                    pin_meta[g] <= 1'b0;
                    pin_s[g]    <= 1'b0;
                end
                else
                begin
                    pin_meta[g] <= pin_raw[g];
                    pin_s[g]    <= pin_meta[g];
                end
            end
        end
    endgenerate

    logic        in_clk_s;
    logic        prst_n_s;
    logic        ws_req_s;
    logic        rate_s;
    logic        clksel_s;
    logic [1:0]  mode1_s;
    logic [1:0]  mode0_s;
    logic [10:0] word_s;
    assign in_clk_s = pin_s[19];
    assign prst_n_s = pin_s[18];
    assign ws_req_s = pin_s[17];
    assign rate_s   = pin_s[16];
    assign clksel_s = pin_s[15];
    assign mode1_s  = pin_s[14:13];
    assign mode0_s  = pin_s[12:11];
    assign word_s   = pin_s[10:0];

    // =====================================================================
    // mode decode
    logic encode_en;
    logic sc_used;
    logic buf_active;
    logic atomic_mode;
    assign encode_en   = !is_lvl(mode1_s, TXPA_LVL_LOW);
    assign sc_used     = !is_lvl(mode0_s, TXPA_LVL_HIGH);
    assign buf_active  = clksel_s || rate_s;
    assign atomic_mode = is_lvl(mode1_s, TXPA_LVL_MID);

    // =====================================================================
    // reference character clock: divider, both edges when rate is high
    logic [3:0] ref_cnt;
    logic       ref_rise;
    logic       ref_tick;
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            ref_cnt <= '0;
        else if (ref_cnt == REF_DIV_LAST)
            ref_cnt <= '0;
        else
            ref_cnt <= ref_cnt + 4'h1;
    end
    assign ref_rise = (ref_cnt == '0);
    assign ref_tick = ref_rise || (rate_s && ref_cnt == REF_DIV_HALF);

    // input clock edge detect on the synchronized copy
    logic in_clk_d;
    logic in_edge;
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            in_clk_d <= 1'b0;
        else
            in_clk_d <= in_clk_s;
    end
    assign in_edge = in_clk_s && !in_clk_d;

    // =====================================================================
    // input register: ten bits always, select bit only when used
    logic [WORD_W-1:0] in_reg;
    logic [WORD_W-1:0] next_in_reg;
    logic              cap_now;
    assign cap_now     = buf_active ? in_edge : ref_rise;
    assign next_in_reg = {word_s[SC_BIT] & sc_used, word_s[SC_BIT-1:0]};
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            in_reg <= '0;
        else if (cap_now)
            in_reg <= next_in_reg;
    end

    // =====================================================================
    // buffer reset: two consecutive low samples at ref rising edges
    logic [1:0] low_cnt;
    logic       init_hold;
    logic       init_release;
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            low_cnt   <= '0;
            init_hold <= 1'b0;
        end
        else if (ref_rise)
        begin
            if (!prst_n_s)
            begin
                if (low_cnt != RST_LOW_EDGES)
                    low_cnt <= low_cnt + 2'h1;
                if (low_cnt + 2'h1 >= RST_LOW_EDGES)
                    init_hold <= 1'b1;
            end
            else
            begin
                low_cnt <= '0;
            end
        end
        else if (prst_n_s && init_hold)
            init_hold <= 1'b0;
    end
    assign init_release = init_hold && prst_n_s && !ref_rise;

    // phase of input clock to ref rise, latched at release
    logic [3:0] phase_cnt;
    logic [3:0] last_phase;
    logic [3:0] phase_ref;
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            phase_cnt  <= '0;
            last_phase <= '0;
            phase_ref  <= '0;
        end
        else
        begin
            phase_cnt <= ref_rise ? 4'h1 : phase_cnt + 4'h1;
            if (in_edge)
                last_phase <= ref_rise ? 4'h0 : phase_cnt;
            if (init_release)
                phase_ref <= last_phase;
        end
    end

    // =====================================================================
    // phase-align buffer
    txpa_buf_if bif ();
    logic sync_recenter;
    logic soft_recenter;
    assign bif.init    = init_hold || sync_recenter || soft_recenter;
    assign bif.wr_en   = buf_active && in_edge && !init_hold;
    assign bif.wr_data = next_in_reg;
    assign bif.rd_en   = buf_active && ref_tick && !init_hold;

    txpa_phase_buf u_buf (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .bus     (bif.buf_side)
    );

    // error stays until the buffer is reinitialized
    logic buf_err;
    logic err_event;
    assign err_event = buf_active && (bif.overflow || bif.underflow);
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            buf_err <= 1'b0;
        else if (err_event)
            buf_err <= 1'b1;
        else if (bif.init)
            buf_err <= 1'b0;
    end

    // =====================================================================
    // word sync sequencer: sixteen commas, never split
    txpa_ws_type ws_state;
    logic [4:0]  ws_cnt;
    logic        ws_req_d;
    logic        ws_start;
    logic        ws_last;
    assign ws_start = ws_req_s && !ws_req_d && atomic_mode;
    assign ws_last  = (ws_state == TXPA_WS_SEND) && ref_tick && ws_cnt == WSYNC_LEN - 5'h1;
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            ws_state      <= TXPA_WS_IDLE;
            ws_cnt        <= '0;
            ws_req_d      <= 1'b0;
            sync_recenter <= 1'b0;
        end
        else
        begin
            ws_req_d      <= ws_req_s;
            sync_recenter <= ws_last && buf_err && atomic_mode;
            case (ws_state)
                TXPA_WS_IDLE:
                begin
                    ws_cnt <= '0;
                    if (ws_start)
                        ws_state <= TXPA_WS_SEND;
                end
                TXPA_WS_SEND:
                begin
                    if (ref_tick)
                        ws_cnt <= ws_cnt + 5'h1;
                    if (ws_last)
                        ws_state <= TXPA_WS_IDLE;
                end
                default:
                    ws_state <= TXPA_WS_IDLE;
            endcase
        end
    end

    // =====================================================================
    // character output, one per ref tick
    logic [WORD_W-1:0] src_word;
    assign src_word = buf_active ? bif.rd_data : in_reg;
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            tx_char_o        <= '0;
            tx_char_valid_o  <= 1'b0;
            tx_special_sel_o <= 1'b0;
            tx_encode_en_o   <= 1'b0;
            tx_violation_o   <= 1'b0;
            tx_comma_o       <= 1'b0;
        end
        else
        begin
            tx_char_valid_o <= ref_tick;
            if (ref_tick)
            begin
                tx_encode_en_o <= encode_en;
                if (ws_state == TXPA_WS_SEND)
                begin
                    tx_char_o        <= {2'b00, COMMA_CODE};
                    tx_special_sel_o <= 1'b0;
                    tx_violation_o   <= 1'b0;
                    tx_comma_o       <= 1'b1;
                end
                else if (buf_err && buf_active)
                begin
                    tx_char_o        <= encode_en ? 10'h000 : VIOLATION_CHAR;
                    tx_special_sel_o <= 1'b0;
                    tx_violation_o   <= 1'b1;
                    tx_comma_o       <= 1'b0;
                end
                else
                begin
                    tx_char_o        <= src_word[9:0];
                    tx_special_sel_o <= src_word[SC_BIT] & encode_en;
                    tx_violation_o   <= 1'b0;
                    tx_comma_o       <= 1'b0;
                end
            end
        end
    end

    // error pin follows the sticky condition
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            tx_error_flag_o <= 1'b0;
        else
            tx_error_flag_o <= buf_err;
    end

    // =====================================================================
    // apb slave: one access cycle, registered answer
    logic       apb_setup;
    logic       apb_wr;
    logic [2:0] int_stat;
    logic [2:0] int_mask;
    logic [2:0] int_set;
    logic       init_hold_d;
    assign apb_setup = psel_i && !penable_i;
    assign apb_wr    = psel_i && penable_i && pready_o && pwrite_i;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= '0;
        end
        else
        begin
            pready_o <= apb_setup;
            if (apb_setup)
            begin
                pslverr_o <= 1'b0;
                prdata_o  <= '0;
                case (paddr_i)
                    REG_CTRL:     prdata_o <= '0;
                    REG_STATUS:   prdata_o <= {16'h0000, 4'h0, phase_ref, 1'b0,
                                               bif.level, (ws_state == TXPA_WS_SEND),
                                               init_hold, buf_active, buf_err};
                    REG_INT_STAT: prdata_o <= {29'h0, int_stat};
                    REG_INT_MASK: prdata_o <= {29'h0, int_mask};
                    default:      pslverr_o <= 1'b1;
                endcase
            end
        end
    end

    // soft recenter pulse and interrupt mask
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            soft_recenter <= 1'b0;
            int_mask      <= INT_MASK_RESET;
        end
        else
        begin
            soft_recenter <= apb_wr && paddr_i == REG_CTRL && pwdata_i[CTRL_RECENTER];
            if (apb_wr && paddr_i == REG_INT_MASK)
                int_mask <= pwdata_i[2:0];
        end
    end

    // sticky events; a set in the clearing cycle wins
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            init_hold_d <= 1'b0;
        else
            init_hold_d <= init_hold;
    end
    assign int_set = {ws_last, init_hold_d && !init_hold, err_event && !buf_err};
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            int_stat <= '0;
        else if (apb_wr && paddr_i == REG_INT_STAT)
            int_stat <= (int_stat & ~pwdata_i[2:0]) | int_set;
        else
            int_stat <= int_stat | int_set;
    end

    // level interrupt from any unmasked sticky bit
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(int_stat & int_mask);
    end

endmodule // txpa_top
`default_nettype wire

// File: verif/txpa_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module txpa_host_model
    import txpa_pkg::*;
(
    // drift control
    input  wire logic              slow_i,
    // character pins
    output logic                   tx_input_clk_o,
    output logic      [DATA_W-1:0] tx_data_o,
    output logic      [CTRL_W-1:0] tx_ctrl_in_o
);
    // =====================================================================
    // host clock: runs free, slow_i stretches it so the buffer drains
    initial
    begin
        tx_input_clk_o = 1'b0;
        tx_data_o = 8'h00;
        tx_ctrl_in_o = 2'h0;
        forever
            #(slow_i ? 50 : 40) tx_input_clk_o = ~tx_input_clk_o;
    end

    // new character on the fall, steady at the capturing rise
    always @(negedge tx_input_clk_o)
    begin
        tx_data_o <= tx_data_o + 8'h01;
        tx_ctrl_in_o <= tx_data_o[1:0]; // ctrl trails data, so a swap shows
    end
endmodule // txpa_host_model
`default_nettype wire

// File: verif/txpa_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module txpa_monitor
    import txpa_pkg::*;
(
    // system and apb
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic       psel_i,
    input wire logic       pwrite_i,
    input wire logic [7:0] paddr_i,
    // selects
    input wire logic [1:0] tx_mode_sel1_i,
    input wire logic [1:0] tx_mode_sel0_i,
    input wire logic       tx_input_clk_sel_i,
    input wire logic       tx_rate_sel_i,
    input wire logic       tx_phase_reset_n_i,
    // character out
    input wire logic [9:0] tx_char_o,
    input wire logic       tx_char_valid_o,
    input wire logic       tx_special_sel_o,
    input wire logic       tx_encode_en_o,
    input wire logic       tx_violation_o,
    input wire logic       tx_comma_o,
    input wire logic       tx_error_flag_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // =====================================================================
    // cycles since anything that may legally clear the error
    logic [4:0] since_clear;
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            since_clear <= 5'h1f;
        else if (!tx_phase_reset_n_i || tx_comma_o || (psel_i && pwrite_i && paddr_i == REG_CTRL))
            since_clear <= 5'h00;
        else if (since_clear != 5'h1f)
            since_clear <= since_clear + 5'h01;
    end

    // =====================================================================
    // properties; mode checks wait out synchronizer and tick lag
    AST_ONE_PULSE: assert property (tx_char_valid_o |=> !tx_char_valid_o [*3])
        else $error("char valid pulse too long");
    AST_ENC_EN: assert property (tx_char_valid_o && $past(tx_mode_sel1_i, 16) == tx_mode_sel1_i
        |-> tx_encode_en_o == (tx_mode_sel1_i != TXPA_LVL_LOW))
        else $error("encoder enable does not follow mode");
    AST_SPECIAL: assert property (tx_char_valid_o && tx_mode_sel0_i == TXPA_LVL_HIGH
        && $past(tx_mode_sel0_i, 16) == TXPA_LVL_HIGH |-> !tx_special_sel_o)
        else $error("special select used in mode0 high");
    AST_VIOL_CHAR: assert property (tx_char_valid_o && tx_violation_o && !tx_encode_en_o
        |-> tx_char_o == VIOLATION_CHAR)
        else $error("wrong bypass violation pattern");
    AST_ERR_VIOL: assert property (tx_char_valid_o && tx_error_flag_o && $past(tx_error_flag_o, 3)
        && !tx_comma_o |-> tx_violation_o)
        else $error("no violation char during error");
    AST_ERR_HOLD: assert property ($fell(tx_error_flag_o) |-> since_clear < 5'h08)
        else $error("error dropped without buffer reset");
    AST_COMMA_CHAR: assert property (tx_char_valid_o && tx_comma_o |-> tx_char_o == 10'h0bc)
        else $error("word sync char not comma");
    AST_ERR_MODE: assert property ($rose(tx_error_flag_o)
        |-> tx_input_clk_sel_i || tx_rate_sel_i)
        else $error("buffer error while buffer bypassed");

    // main scenarios reached
    CVR_COMMA: cover property (tx_char_valid_o && tx_comma_o);
    CVR_ERR: cover property ($rose(tx_error_flag_o));
    CVR_VIOL: cover property (tx_char_valid_o && tx_violation_o);
endmodule // txpa_monitor
`default_nettype wire

// File: verif/tx_input_phase_align_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tx_input_phase_align_tb;
    import txpa_pkg::*;
    // =====================================================================
    // signals
    logic       clk_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irq_o;
    logic       tx_input_clk_i, special_char_sel_i, tx_input_clk_sel_i, tx_rate_sel_i;
    logic       tx_phase_reset_n_i, word_sync_req_i, slow, e;
    logic       tx_char_valid_o, tx_special_sel_o, tx_encode_en_o, tx_violation_o;
    logic       tx_comma_o, tx_error_flag_o;
    logic [7:0] paddr_i, tx_data_i;
    logic [1:0] tx_ctrl_in_i, tx_mode_sel1_i, tx_mode_sel0_i;
    logic [9:0] tx_char_o;
    logic [31:0] pwdata_i, prdata_o, q;
    int         bad_count, checked;

    txpa_top i_txpa_top (.*);
    txpa_host_model i_txpa_host_model (.slow_i(slow), .tx_input_clk_o(tx_input_clk_i),
        .tx_data_o(tx_data_i), .tx_ctrl_in_o(tx_ctrl_in_i));

    // =====================================================================
    // tasks
    task automatic complete_run();
        $display("checks %0d errors %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // a wait that runs out is a mismatch
    task automatic give_up();
        bad_count++;
        complete_run();
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one apb transfer
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do
        begin
            @(posedge clk_i);
            if (++n > 20)
                give_up();
        end
        while (pready_o !== 1'b1);
        q = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    // next character, settled
    task automatic next_char();
        int n;
        n = 0;
        do
        begin
            @(posedge clk_i);
            #1;
            if (++n > 40)
                give_up();
        end
        while (tx_char_valid_o !== 1'b1);
    endtask
    // host count, or violation pattern
    task automatic watch(input int n, input logic viol);
        logic [7:0] last;
        last = 8'h00;
        for (int i = 0; i <= n; i++)
        begin
            next_char();
            if (viol)
                chk("viol_char", VIOLATION_CHAR, tx_char_o);
            else if (i > 0)
                chk("char", {last[1:0], last + 8'h01}, tx_char_o);
            last = tx_char_o[7:0];
            chk("encode_en", tx_mode_sel1_i != TXPA_LVL_LOW, tx_encode_en_o);
        end
    endtask
    task automatic wait_err(input logic v);
        int n;
        n = 0;
        while (tx_error_flag_o !== v)
        begin
            @(posedge clk_i);
            if (++n > 4000)
                give_up();
        end
    endtask

    // =====================================================================
    // clock
    initial
    begin
        clk_i = 1'b0;
        forever
            #5 clk_i = ~clk_i;
    end

    // =====================================================================
    // main sequence
    initial
    begin
        {psel_i, penable_i, pwrite_i, tx_input_clk_sel_i, tx_rate_sel_i} = '0;
        {word_sync_req_i, slow, bad_count, checked} = '0;
        special_char_sel_i = 1'b1;
        paddr_i = 8'h00;
        pwdata_i = 32'h0;
        tx_mode_sel1_i = TXPA_LVL_LOW;
        tx_mode_sel0_i = TXPA_LVL_HIGH;
        tx_phase_reset_n_i = 1'b1;
        rst_n_i = 1'b0;
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        apb(1'b0, REG_INT_MASK, 32'h0);
        chk("int_mask", 32'h0, q);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped_err", 32'h1, e);
        // bypass: direct path, pre-encoded character
        apb(1'b0, REG_STATUS, 32'h0);
        chk("buf_active", 32'h0, q[1]);
        watch(6, 1'b0);
        chk("special", 32'h0, tx_special_sel_o);
        // buffered path after phase reset
        @(posedge clk_i);
        tx_input_clk_sel_i <= 1'b1;
        tx_phase_reset_n_i <= 1'b0;
        repeat (24) @(posedge clk_i);
        apb(1'b0, REG_STATUS, 32'h0);
        chk("init_held", 32'h1, q[2]);
        tx_phase_reset_n_i <= 1'b1;
        repeat (60) @(posedge clk_i);
        apb(1'b0, REG_STATUS, 32'h0);
        chk("buf_active", 32'h2, q[1:0]);
        watch(6, 1'b0);
        // encoder on, special select captured
        @(posedge clk_i);
        tx_mode_sel1_i <= TXPA_LVL_HIGH;
        tx_mode_sel0_i <= TXPA_LVL_LOW;
        repeat (30) @(posedge clk_i);
        watch(4, 1'b0);
        chk("special", 32'h1, tx_special_sel_o);
        // drift beyond tolerance in encoder bypass
        @(posedge clk_i);
        tx_mode_sel1_i <= TXPA_LVL_LOW;
        apb(1'b1, REG_INT_MASK, 32'h1);
        slow <= 1'b1;
        wait_err(1'b1);
        repeat (3) @(posedge clk_i);
        chk("irq", 32'h1, irq_o);
        watch(4, 1'b1);
        @(posedge clk_i);
        slow <= 1'b0;
        tx_mode_sel1_i <= TXPA_LVL_MID;
        repeat (100) @(posedge clk_i);
        chk("err_held", 32'h1, tx_error_flag_o);
        // word sync recenters and clears
        @(posedge clk_i);
        word_sync_req_i <= 1'b1;
        for (int i = 0; i < 4 && tx_comma_o !== 1'b1; i++)
            next_char();
        for (int i = 1; i < 16; i++)
        begin
            next_char();
            chk("comma_run", 32'h1, tx_comma_o);
        end
        next_char();
        chk("comma_end", 32'h0, tx_comma_o);
        @(posedge clk_i);
        word_sync_req_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        chk("err_clear", 32'h0, tx_error_flag_o);
        apb(1'b0, REG_INT_STAT, 32'h0);
        chk("int_stat", 32'h7, q);
        apb(1'b1, REG_INT_STAT, 32'h7);
        apb(1'b0, REG_INT_STAT, 32'h0);
        chk("int_clear", 32'h0, q);
        repeat (3) @(posedge clk_i);
        chk("irq", 32'h0, irq_o);
        complete_run();
    end
endmodule // tx_input_phase_align_tb

bind txpa_top txpa_monitor i_txpa_monitor (.*);
`default_nettype wire
